// file: logic/oafr_params.svh
/*
 Timing, field and reset constants for the overload alarm and fault relay block.
 Assumes ref_clk at 25 MHz and APB byte addressing with one aligned word per register.
*/
`ifndef OAFR_PARAMS_SVH
`define OAFR_PARAMS_SVH
`define OAFR_CLK_HZ          25000000
`define OAFR_TICK_MS         1
`define OAFR_TICK_CYC        ((`OAFR_CLK_HZ / 1000) * `OAFR_TICK_MS)
`define OAFR_OFF_WARN        12'h000
`define OAFR_OFF_TRIP        12'h004
`define OAFR_OFF_RELAY       12'h008
`define OAFR_OFF_STATUS      12'h00c
`define OAFR_OFF_IRQ_STAT    12'h010
`define OAFR_OFF_IRQ_EN      12'h014
`define OAFR_OFF_IRQ_CLR     12'h018
`define OAFR_OFF_MFO_SEL     12'h01c
`define OAFR_WARN_LVL_RST    8'd150
`define OAFR_WARN_TIME_RST   6'd10
`define OAFR_TRIP_LVL_RST    8'd180
`define OAFR_TRIP_TIME_RST   6'd60
`define OAFR_TRIP_EN_RST     1'b1
`define OAFR_RELAY_RST       3'b011
`define OAFR_LVL_MIN         8'd30
`define OAFR_LVL_MAX         8'd250
`define OAFR_WARN_TIME_MAX   6'd30
`define OAFR_TRIP_TIME_MAX   6'd60
`define OAFR_MFO_OVERLOAD    5'd16
`define OAFR_MFO_STOP        5'd17
`define OAFR_MFO_STEADY      5'd18
`endif

// file: logic/oafr_pkg.sv
/*
 Types for the overload alarm and fault relay block.
 Assumes oafr_params.svh holds the numeric constants.
*/
package oafr_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } oafr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } oafr_apb_rsp_t;

  typedef struct packed {
    logic running;
    logic accel;
    logic decel;
    logic uv_trip;
    logic other_trip;
    logic retry;
  } oafr_drv_state_t;

  typedef enum logic [1:0] {
    OAFR_TMR_IDLE  = 2'b00,
    OAFR_TMR_COUNT = 2'b01,
    OAFR_TMR_DONE  = 2'b10
  } oafr_tmr_state_t;
endpackage : oafr_pkg

// file: logic/oafr_top.sv
/*
 Overload warning, overload trip, status and fault relay outputs with APB registers.
 Assumes current_pct and drv_state come from logic on ref_clk as percent of rated
 motor current; the drive interprets gate_block and trip_flag.
*/
// Our own choices: the register offsets and the APB interface to the registers.
// Operation
// - Warning asserts after current stays above level beyond warning time.
// - Warning clears after current stays below level beyond warning time.
// - Overload output function drives selected output; motor keeps running.
// - Warning level 30..250 percent default 150; time 0..30 s default 10.
// - Stop output active while inverter stays stopped.
// - Steady output active only at constant running speed.
// - Three-bit relay mode, default 011, selects relay fault sources.
// - Mode bit 0 gates relay on undervoltage trip.
// - Mode bit 1 gates relay on any other trip.
// - Mode bit 2 gates relay on auto-retry attempts.
// - Enabled trip blocks gating after current above trip level for trip time.
// - Trip level 30..250 percent; time 0..60 s; trip enabled by default.
`timescale 1ns/1ps
`include "oafr_params.svh"

module oafr_top #(
  parameter int TICK_CYC = `OAFR_TICK_CYC
) (
  input  wire logic                     ref_clk,        // 25 MHz clock
  input  wire logic                     resetn,         // Async reset, active low
  input  wire oafr_pkg::oafr_apb_req_t  apb_req,        // APB request
  output logic                          prdata_valid,   // Unused-free marker, mirrors pready
  output oafr_pkg::oafr_apb_rsp_t       apb_rsp,        // APB response
  input  wire logic [7:0]               current_pct,    // Output current, % of rated
  input  wire oafr_pkg::oafr_drv_state_t drv_state,     // Drive run/trip state
  output logic                          open_collector_output, // Selected status output
  output logic                          overload_warn,  // Overload warning level
  output logic                          stop_status,    // Inverter stopped
  output logic                          steady_status,  // Constant speed
  output logic                          fault_relay,    // Fault relay coil
  output logic                          gate_block,     // Block power-switch gating
  output logic                          trip_flag,      // Overload trip raised
  output logic                          irq             // Level interrupt
);
  import oafr_pkg::*;

  logic [7:0]  warn_lvl_reg;
  logic [5:0]  warn_time_reg;
  logic [7:0]  trip_lvl_reg;
  logic [5:0]  trip_time_reg;
  logic        trip_en_reg;
  logic [2:0]  relay_mode_reg;
  logic [4:0]  mfo_sel_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_en_reg;
  logic [31:0] tick_cnt_reg;
  logic        tick;
  logic [15:0] warn_on_cnt_reg;
  logic [15:0] warn_off_cnt_reg;
  logic [15:0] trip_cnt_reg;
  logic        warn_reg;
  logic        trip_reg;
  logic        relay_next;
  logic        mfo_next;
  logic        bus_wr;
  logic        bus_rd;
  logic        wr_clr;
  logic [31:0] rdata_next;
  logic        addr_ok;
  logic [15:0] warn_lim;
  logic [15:0] trip_lim;
  logic        above_warn;
  logic        above_trip;
  logic        warn_rise;
  logic        trip_rise;

  // Tick of one millisecond; all overload durations count in ticks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  assign warn_lim   = 16'(warn_time_reg) * 16'd1000;
  assign trip_lim   = 16'(trip_time_reg) * 16'd1000;
  assign above_warn = (current_pct > warn_lvl_reg);
  assign above_trip = (current_pct > trip_lvl_reg);

  // Warning set/clear durations; each restarts when its condition breaks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      warn_on_cnt_reg  <= 16'h0000;
      warn_off_cnt_reg <= 16'h0000;
      warn_reg         <= 1'b0;
    end else begin
      if (!above_warn || warn_reg) begin
        warn_on_cnt_reg <= 16'h0000;
      end else if (tick) begin
        warn_on_cnt_reg <= warn_on_cnt_reg + 16'h0001;
      end
      if (above_warn || !warn_reg) begin
        warn_off_cnt_reg <= 16'h0000;
      end else if (tick) begin
        warn_off_cnt_reg <= warn_off_cnt_reg + 16'h0001;
      end
      // Strictly longer than the set time: count must pass the limit
      if (!warn_reg && above_warn && tick && warn_on_cnt_reg >= warn_lim) begin
        warn_reg <= 1'b1;
      end else if (warn_reg && !above_warn && tick && warn_off_cnt_reg >= warn_lim) begin
        warn_reg <= 1'b0;
      end
    end
  end
  assign warn_rise = !warn_reg && above_warn && tick && (warn_on_cnt_reg >= warn_lim);

  // Trip is latched; only reset clears it since restart is the drive's business
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trip_cnt_reg <= 16'h0000;
      trip_reg     <= 1'b0;
    end else begin
      if (!above_trip || !trip_en_reg) begin
        trip_cnt_reg <= 16'h0000;
      end else if (tick && trip_cnt_reg < trip_lim) begin
        trip_cnt_reg <= trip_cnt_reg + 16'h0001;
      end
      if (trip_rise) begin
        trip_reg <= 1'b1;
      end
    end
  end
  assign trip_rise = !trip_reg && trip_en_reg && above_trip && (trip_cnt_reg >= trip_lim);

  always_comb begin
    relay_next = (relay_mode_reg[0] & drv_state.uv_trip)
               | (relay_mode_reg[1] & (drv_state.other_trip | trip_reg))
               | (relay_mode_reg[2] & drv_state.retry);
    case (mfo_sel_reg)
      `OAFR_MFO_OVERLOAD: mfo_next = warn_reg;
      `OAFR_MFO_STOP:     mfo_next = !drv_state.running;
      `OAFR_MFO_STEADY:   mfo_next = drv_state.running && !drv_state.accel && !drv_state.decel;
      default:            mfo_next = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      open_collector_output <= 1'b0;
      overload_warn         <= 1'b0;
      stop_status           <= 1'b0;
      steady_status         <= 1'b0;
      fault_relay           <= 1'b0;
      gate_block            <= 1'b0;
      trip_flag             <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      open_collector_output <= mfo_next;
      overload_warn         <= warn_reg;
      stop_status           <= !drv_state.running;
      steady_status         <= drv_state.running && !drv_state.accel && !drv_state.decel;
      fault_relay           <= relay_next;
      gate_block            <= trip_reg;
      trip_flag             <= trip_reg;
      irq                   <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // APB slave: zero wait states, error on unmapped offsets
  assign bus_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign bus_rd = apb_req.psel && !apb_req.pwrite;
  assign wr_clr = bus_wr && (apb_req.paddr == `OAFR_OFF_IRQ_CLR);

  always_comb begin
    addr_ok    = 1'b1;
    rdata_next = 32'h0000_0000;
    case (apb_req.paddr)
      `OAFR_OFF_WARN:     rdata_next = {18'h0, warn_time_reg, warn_lvl_reg};
      `OAFR_OFF_TRIP:     rdata_next = {17'h0, trip_en_reg, trip_time_reg, trip_lvl_reg};
      `OAFR_OFF_RELAY:    rdata_next = {29'h0, relay_mode_reg};
      `OAFR_OFF_STATUS:   rdata_next = {27'h0, fault_relay, steady_status, stop_status,
                                        trip_reg, warn_reg};
      `OAFR_OFF_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
      `OAFR_OFF_IRQ_EN:   rdata_next = {29'h0, irq_en_reg};
      `OAFR_OFF_IRQ_CLR:  rdata_next = 32'h0000_0000;
      `OAFR_OFF_MFO_SEL:  rdata_next = {27'h0, mfo_sel_reg};
      default:            addr_ok    = 1'b0;
    endcase
  end

  // Out-of-range settings are ignored so the stored value stays legal
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      warn_lvl_reg   <= `OAFR_WARN_LVL_RST;
      warn_time_reg  <= `OAFR_WARN_TIME_RST;
      trip_lvl_reg   <= `OAFR_TRIP_LVL_RST;
      trip_time_reg  <= `OAFR_TRIP_TIME_RST;
      trip_en_reg    <= `OAFR_TRIP_EN_RST;
      relay_mode_reg <= `OAFR_RELAY_RST;
      mfo_sel_reg    <= `OAFR_MFO_OVERLOAD;
      irq_en_reg     <= 3'b000;
    end else if (bus_wr) begin
      case (apb_req.paddr)
        `OAFR_OFF_WARN: begin
          if (apb_req.pwdata[7:0] >= `OAFR_LVL_MIN && apb_req.pwdata[7:0] <= `OAFR_LVL_MAX)
            warn_lvl_reg <= apb_req.pwdata[7:0];
          if (apb_req.pwdata[13:8] <= `OAFR_WARN_TIME_MAX)
            warn_time_reg <= apb_req.pwdata[13:8];
        end
        `OAFR_OFF_TRIP: begin
          if (apb_req.pwdata[7:0] >= `OAFR_LVL_MIN && apb_req.pwdata[7:0] <= `OAFR_LVL_MAX)
            trip_lvl_reg <= apb_req.pwdata[7:0];
          if (apb_req.pwdata[13:8] <= `OAFR_TRIP_TIME_MAX)
            trip_time_reg <= apb_req.pwdata[13:8];
          trip_en_reg <= apb_req.pwdata[14];
        end
        `OAFR_OFF_RELAY:   relay_mode_reg <= apb_req.pwdata[2:0];
        `OAFR_OFF_IRQ_EN:  irq_en_reg     <= apb_req.pwdata[2:0];
        `OAFR_OFF_MFO_SEL: mfo_sel_reg    <= apb_req.pwdata[4:0];
        default: ;
      endcase
    end
  end

  // Sticky events: set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= 3'b000;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? apb_req.pwdata[2:0] : 3'b000))
                    | {relay_next & !fault_relay, trip_rise, warn_rise};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      apb_rsp      <= '0;
      prdata_valid <= 1'b0;
    end else begin
      apb_rsp.pready  <= apb_req.psel && !apb_req.penable;
      apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && !addr_ok;
      apb_rsp.prdata  <= (bus_rd && !apb_req.penable) ? rdata_next : 32'h0000_0000;
      prdata_valid    <= apb_req.psel && !apb_req.penable;
    end
  end
endmodule : oafr_top

// file: bench/oafr_top_checker.sv
/* Port assertions for the overload block.
 Assumes a bind to oafr_top and the single clock ref_clk. */
`timescale 1ns/1ps
module oafr_top_checker (
  input wire logic                      ref_clk,      // Clock
  input wire logic                      resetn,       // Reset, low
  input wire oafr_pkg::oafr_apb_req_t   apb_req,      // Request
  input wire logic                      prdata_valid, // Ready copy
  input wire oafr_pkg::oafr_apb_rsp_t   apb_rsp,      // Response
  input wire logic [7:0]                current_pct,  // Current
  input wire oafr_pkg::oafr_drv_state_t drv_state,    // Drive state
  input wire logic                      open_collector_output, // Output
  input wire logic                      overload_warn, // Warning
  input wire logic                      stop_status,  // Stopped
  input wire logic                      steady_status, // Steady
  input wire logic                      fault_relay,  // Relay
  input wire logic                      gate_block,   // Gating off
  input wire logic                      trip_flag,    // Trip
  input wire logic                      irq           // Interrupt
);
  import oafr_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_stop_while_stopped: assert property (!drv_state.running |=> stop_status)
    else $error("stop output low while stopped");
  a_steady_exact: assert property (1'b1 |=> steady_status ==
    $past(drv_state.running && !drv_state.accel && !drv_state.decel))
    else $error("steady output wrong");
  a_relay_has_cause: assert property (fault_relay |-> trip_flag ||
    $past(drv_state.uv_trip || drv_state.other_trip || drv_state.retry))
    else $error("relay active without cause");
  a_gate_with_trip: assert property (gate_block == trip_flag)
    else $error("gating block differs from trip");
  a_trip_sticks: assert property (trip_flag |=> trip_flag)
    else $error("trip dropped");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_setup_answered: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready in access phase");
  a_warn_rise_above: assert property ($rose(overload_warn) |-> $past(current_pct) > 8'h1e)
    else $error("warning rose at low current");
  a_warn_fall_below: assert property ($fell(overload_warn) |-> $past(current_pct) <= 8'hfa)
    else $error("warning fell at high current");
  cover property ($rose(overload_warn));
  cover property ($rose(trip_flag));
  cover property ($rose(fault_relay) && !trip_flag);
endmodule : oafr_top_checker

bind oafr_top oafr_top_checker u_chk (.ref_clk, .resetn, .apb_req, .prdata_valid,
  .apb_rsp, .current_pct, .drv_state, .open_collector_output, .overload_warn,
  .stop_status, .steady_status, .fault_relay, .gate_block, .trip_flag, .irq);

// file: bench/oafr_load_model.sv
/* External load: relay contact and open-collector lamp.
 Assumes the drive outputs are registered on ref_clk. */
`timescale 1ns/1ps
module oafr_load_model (
  input  wire logic ref_clk,               // Clock
  input  wire logic fault_relay,           // Coil drive
  input  wire logic open_collector_output, // Lamp drive
  output logic      relay_closed,          // Contact state
  output logic      lamp_on                // Lamp state
);
  // Contact picks up one cycle after the coil, like a slow relay
  always_ff @(posedge ref_clk) begin
    relay_closed <= fault_relay;
    lamp_on      <= open_collector_output;
  end
endmodule : oafr_load_model

// file: bench/overload_alarm_fault_relay_tb.sv
/* Self-checking bench for the overload block.
 Assumes TICK_CYC of 2, so one second setting lasts 2000 cycles. */
`timescale 1ns/1ps
`include "oafr_params.svh"
module overload_alarm_fault_relay_tb;
  import oafr_pkg::*;
  logic            ref_clk = 1'b0;
  logic            resetn = 1'b0;
  oafr_apb_req_t   req = '0;
  oafr_apb_rsp_t   rsp;
  logic [7:0]      cur = 8'h00;
  oafr_drv_state_t ds = '0;
  logic            pv, oc, warn, stp, stdy, rly, gb, tf, irq, rc, lamp, err;
  logic [31:0]     rd;
  int              fail_count = 0;
  int              cmp_count = 0;
  int              n;
  oafr_top #(.TICK_CYC(2)) dut (.ref_clk(ref_clk), .resetn(resetn), .apb_req(req),
    .prdata_valid(pv), .apb_rsp(rsp), .current_pct(cur), .drv_state(ds),
    .open_collector_output(oc), .overload_warn(warn), .stop_status(stp),
    .steady_status(stdy), .fault_relay(rly), .gate_block(gb), .trip_flag(tf), .irq(irq));
  oafr_load_model u_load (.ref_clk(ref_clk), .fault_relay(rly),
    .open_collector_output(oc), .relay_closed(rc), .lamp_on(lamp));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge ref_clk) req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk) req.penable <= 1'b1;
    do @(posedge ref_clk) w++; while (rsp.pready !== 1'b1 && w < 20);
    if (w >= 20) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, rsp.pready, 1'b1);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  // Counts cycles until warning or trip reaches v
  task automatic wt(input logic trip, input logic v, output int k);
    k = 0;
    while ((trip ? tf : warn) !== v && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
  endtask : wt
  task automatic t_reset_vals;
    apb(1'b0, `OAFR_OFF_WARN, 32'h0);
    chk(rd, 32'h0000_0a96);
    apb(1'b0, `OAFR_OFF_TRIP, 32'h0);
    chk(rd, 32'h0000_7cb4);
    apb(1'b0, `OAFR_OFF_RELAY, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b1, `OAFR_OFF_WARN, 32'h0000_1ffb);
    apb(1'b0, `OAFR_OFF_WARN, 32'h0);
    chk(rd, 32'h0000_0a96);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
  endtask : t_reset_vals
  task automatic t_status;
    cyc(3);
    chk({stp, stdy}, 2'b10);
    ds <= 6'b100000;
    cyc(3);
    chk({stp, stdy}, 2'b01);
    ds.accel <= 1'b1;
    cyc(3);
    chk(stdy, 1'b0);
  endtask : t_status
  task automatic t_relay;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, `OAFR_OFF_RELAY, 32'(m));
      for (int k = 0; k < 3; k++) begin
        ds <= 6'(1 << (2 - k));
        cyc(3);
        chk(rly, (m >> k) & 1);
      end
    end
    ds <= 6'b100000;
    apb(1'b1, `OAFR_OFF_IRQ_CLR, 32'h7);
  endtask : t_relay
  task automatic t_warning;
    apb(1'b1, `OAFR_OFF_WARN, 32'h0000_0164);
    cur <= 8'd101;
    cyc(1500);
    cur <= 8'd100;
    cyc(4);
    cur <= 8'd120;
    wt(1'b0, 1'b1, n);
    chk(n >= 2000 && n < 2100, 1'b1);
    chk({oc, gb, tf, irq}, 4'b1000);
    apb(1'b0, `OAFR_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `OAFR_OFF_IRQ_EN, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    cur <= 8'd60;
    wt(1'b0, 1'b0, n);
    chk(n >= 2000 && n < 2100, 1'b1);
    apb(1'b1, `OAFR_OFF_IRQ_CLR, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
  endtask : t_warning
  task automatic t_trip;
    apb(1'b1, `OAFR_OFF_RELAY, 32'h2);
    apb(1'b1, `OAFR_OFF_TRIP, 32'h0000_41c8);
    apb(1'b0, `OAFR_OFF_TRIP, 32'h0);
    chk(rd, 32'h0000_41c8);
    cur <= 8'd201;
    wt(1'b1, 1'b1, n);
    chk(n >= 2000 && n < 2100, 1'b1);
    chk({gb, rly}, 2'b11);
    cyc(2);
    chk(rc, 1'b1);
  endtask : t_trip
  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset_vals();
    t_status();
    t_relay();
    t_warning();
    t_trip();
    report_and_stop();
  end
  // Whole run needs about 7700 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end
endmodule : overload_alarm_fault_relay_tb
